// ---- logic/afx_ctrl.sv ----
// Host controller that drives two asynchronous FIFO channels from APB.
`default_nettype none

// ============================================================================
// One channel engine: sequences one pin cycle per command.
module afx_chan
  import afx_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Command side
  input  wire logic          cmd_valid,
  input  wire logic [2:0]    cmd_op,
  input  wire logic [DW-1:0] cmd_data,
  input  wire logic          depth_mode,
  input  wire logic          first_load_lvl,
  input  wire logic          full_ok,
  input  wire logic          empty_ok,
  input  wire logic [DW-1:0] out_sync,
  output logic               busy,
  output logic               err,
  output logic [DW-1:0]      rdata,
  // FIFO pins
  output logic               w_n,
  output logic               r_n,
  output logic               fifo_reset_n,
  output logic               retransmit_n,
  output logic [DW-1:0]      in_bus
);
  afx_state_e      state_reg, state_next;
  logic [4:0]      cnt_reg, cnt_next;
  logic [2:0]      op_reg, op_next;
  logic            err_reg, err_next;
  logic [DW-1:0]   rdata_reg, rdata_next;
  logic [DW-1:0]   din_reg, din_next;
  logic            w_reg, w_next, r_reg, r_next;
  logic            rs_reg, rs_next, rt_reg, rt_next;
  logic            refuse;

  always_comb begin
    // Writes only while not full, reads only while not empty.
    refuse = ((cmd_op == OP_WRITE) && !full_ok) ||
             ((cmd_op == OP_READ) && !empty_ok) ||
             ((cmd_op == OP_RETX) && depth_mode) ||
             (cmd_op == OP_NONE) || (cmd_op > OP_RETX);
    state_next = state_reg;
    cnt_next   = cnt_reg;
    op_next    = op_reg;
    err_next   = err_reg;
    rdata_next = rdata_reg;
    din_next   = din_reg;
    w_next     = w_reg;
    r_next     = r_reg;
    rs_next    = rs_reg;
    rt_next    = rt_reg;
    case (state_reg)
      AFX_IDLE: begin
        if (cmd_valid) begin
          err_next = refuse;
          if (!refuse) begin
            op_next    = cmd_op;
            state_next = AFX_LOW;
            case (cmd_op)
              OP_RESET: begin
                rs_next  = 1'b0;
                cnt_next = RS_LOW_CNT;
              end
              OP_WRITE: begin
                w_next   = 1'b0;
                din_next = cmd_data;
                cnt_next = WR_LOW_CNT;
              end
              OP_READ: begin
                r_next   = 1'b0;
                cnt_next = RD_LOW_CNT;
              end
              default: begin
                rt_next  = 1'b0;
                cnt_next = WR_LOW_CNT;
              end
            endcase
          end
        end
      end
      AFX_LOW: begin
        if (cnt_reg == 5'h00) begin
          // Read data is taken before the strobe rises and the bus floats.
          if (op_reg == OP_READ) begin
            rdata_next = out_sync;
          end
          w_next     = 1'b1;
          r_next     = 1'b1;
          rs_next    = 1'b1;
          rt_next    = 1'b1;
          // Flags are given time to settle before the next command.
          cnt_next   = (op_reg == OP_RESET) ? RS_REC_CNT : REC_CNT;
          state_next = AFX_HIGH;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      AFX_HIGH: begin
        if (cnt_reg == 5'h00) begin
          state_next = AFX_IDLE;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      default: state_next = AFX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= AFX_IDLE;
      cnt_reg   <= 5'h00;
      op_reg    <= OP_NONE;
      err_reg   <= 1'b0;
      rdata_reg <= '0;
      din_reg   <= '0;
      w_reg     <= 1'b1;
      r_reg     <= 1'b1;
      rs_reg    <= 1'b1;
      rt_reg    <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      op_reg    <= op_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
      din_reg   <= din_next;
      w_reg     <= w_next;
      r_reg     <= r_next;
      rs_reg    <= rs_next;
      rt_reg    <= rt_next;
    end
  end

  assign busy         = (state_reg != AFX_IDLE);
  assign err          = err_reg;
  assign rdata        = rdata_reg;
  assign w_n          = w_reg;
  assign r_n          = r_reg;
  assign fifo_reset_n = rs_reg;
  assign in_bus       = din_reg;
  // In depth mode the shared pin carries the first-load level instead.
  assign retransmit_n = depth_mode ? first_load_lvl : rt_reg;
endmodule

// ============================================================================
// Top: APB slave, pin synchronisers and two channel engines.
module afx_ctrl
  import afx_pkg::*;
(
  // APB
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Channel 0 pins
  output logic               w0_n,
  output logic               r0_n,
  output logic               fifo_reset0_n,
  output logic               retransmit0_n,
  output logic [DW-1:0]      in_bus0,
  input  wire logic [DW-1:0] out_bus0,
  input  wire logic          full_flag0_n,
  input  wire logic          empty_flag0_n,
  input  wire logic          half_full_flag0_n,
  // Channel 1 pins
  output logic               w1_n,
  output logic               r1_n,
  output logic               fifo_reset1_n,
  output logic               retransmit1_n,
  output logic [DW-1:0]      in_bus1,
  input  wire logic [DW-1:0] out_bus1,
  input  wire logic          full_flag1_n,
  input  wire logic          empty_flag1_n,
  input  wire logic          half_full_flag1_n
);
  localparam int NS = 2 * DW + 6;
  logic [NS-1:0]   pin_raw, s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [3:0]      ctrl_reg, ctrl_next;
  logic [1:0]      go_reg, go_next;
  logic [2:0]      op0_reg, op0_next, op1_reg, op1_next;
  logic [DW-1:0]   dat0_reg, dat0_next, dat1_reg, dat1_next;
  logic [31:0]     prdata_reg, prdata_next;
  logic            err_reg, err_next;
  logic [2:0]      fl0, fl1, comp, use0, use1;
  logic [1:0]      mode;
  logic            gang, acc, hit;
  logic [1:0]      busy, cerr;
  logic [DW-1:0]   rd0, rd1;

  // ==========================================================================
  // Pin synchronisers; a change counts once stages two and three agree.
  assign pin_raw = {out_bus1, out_bus0, half_full_flag1_n, full_flag1_n,
                    empty_flag1_n, half_full_flag0_n, full_flag0_n,
                    empty_flag0_n};
  always_comb begin
    filt_next = filt_reg;
    for (int i = 0; i < NS; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg   <= '1;
      s2_reg   <= '1;
      s3_reg   <= '1;
      filt_reg <= '1;
    end else begin
      s1_reg   <= pin_raw;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // ==========================================================================
  // Flag selection: {half_full, full, empty}, all active low.
  assign mode = ctrl_reg[CTRL_MODE_LSB +: 2];
  // Single mode relies on the board grounding each chain-in pin.
  assign gang = (mode != MODE_INDEP);
  assign fl0  = filt_reg[2:0];
  assign fl1  = filt_reg[5:3];
  // Composite full and empty are asserted only when both chained devices assert them; composite half-full is never asserted.
  assign comp = {1'b1, fl0[1:0] | fl1[1:0]};
  always_comb begin
    case (mode)
      MODE_WIDTH: begin
        use0 = fl0;
        use1 = fl0;
      end
      MODE_DEPTH: begin
        use0 = comp;
        use1 = comp;
      end
      default: begin
        use0 = fl0;
        use1 = fl1;
      end
    endcase
  end

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped addresses.
  assign acc = psel && penable;
  assign hit = (paddr == OFF_CTRL) || (paddr == OFF_CMD0) ||
               (paddr == OFF_CMD1) || (paddr == OFF_STATUS) ||
               (paddr == OFF_RDATA0) || (paddr == OFF_RDATA1);
  always_comb begin
    ctrl_next   = ctrl_reg;
    go_next     = 2'b00;
    op0_next    = op0_reg;
    op1_next    = op1_reg;
    dat0_next   = dat0_reg;
    dat1_next   = dat1_reg;
    prdata_next = prdata_reg;
    err_next    = 1'b0;
    if (psel && !penable) begin
      err_next    = !hit;
      prdata_next = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          OFF_CTRL:   prdata_next = {28'h0, ctrl_reg};
          OFF_STATUS: prdata_next = {13'h0, use0,
                                     3'h0, cerr[1], busy[1], fl1,
                                     3'h0, cerr[0], busy[0], fl0};
          OFF_RDATA0: prdata_next = gang ? {14'h0, rd1, rd0}
                                         : {23'h0, rd0};
          OFF_RDATA1: prdata_next = {23'h0, rd1};
          default:    prdata_next = 32'h0000_0000;
        endcase
      end
    end
    if (acc && pwrite) begin
      if (paddr == OFF_CTRL && busy == 2'b00) begin
        ctrl_next = pwdata[3:0];
      end
      // A command to a busy channel is dropped; busy shows in STATUS.
      if (paddr == OFF_CMD0 && busy == 2'b00) begin
        op0_next  = pwdata[CMD_OP_LSB +: 3];
        dat0_next = pwdata[CMD_DATA_LSB +: DW];
        op1_next  = pwdata[CMD_OP_LSB +: 3];
        dat1_next = (mode == MODE_WIDTH) ? pwdata[DW +: DW]
                                         : pwdata[CMD_DATA_LSB +: DW];
        go_next   = gang ? 2'b11 : 2'b01;
      end
      if (paddr == OFF_CMD1 && !gang && !busy[1]) begin
        op1_next  = pwdata[CMD_OP_LSB +: 3];
        dat1_next = pwdata[CMD_DATA_LSB +: DW];
        go_next   = 2'b10;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= CTRL_RESET;
      go_reg     <= 2'b00;
      op0_reg    <= OP_NONE;
      op1_reg    <= OP_NONE;
      dat0_reg   <= '0;
      dat1_reg   <= '0;
      prdata_reg <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      go_reg     <= go_next;
      op0_reg    <= op0_next;
      op1_reg    <= op1_next;
      dat0_reg   <= dat0_next;
      dat1_reg   <= dat1_next;
      prdata_reg <= prdata_next;
      err_reg    <= err_next;
    end
  end
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = err_reg;

  // ==========================================================================
  // Channel engines.
  afx_chan u_ch0 (
    .pclk           (pclk),
    .presetn        (presetn),
    .cmd_valid      (go_reg[0]),
    .cmd_op         (op0_reg),
    .cmd_data       (dat0_reg),
    .depth_mode     (mode == MODE_DEPTH),
    .first_load_lvl (ctrl_reg[CTRL_FL0_BIT]),
    .full_ok        (use0[1]),
    .empty_ok       (use0[0]),
    .out_sync       (filt_reg[6 +: DW]),
    .busy           (busy[0]),
    .err            (cerr[0]),
    .rdata          (rd0),
    .w_n            (w0_n),
    .r_n            (r0_n),
    .fifo_reset_n   (fifo_reset0_n),
    .retransmit_n   (retransmit0_n),
    .in_bus         (in_bus0)
  );
  afx_chan u_ch1 (
    .pclk           (pclk),
    .presetn        (presetn),
    .cmd_valid      (go_reg[1]),
    .cmd_op         (op1_reg),
    .cmd_data       (dat1_reg),
    .depth_mode     (mode == MODE_DEPTH),
    .first_load_lvl (ctrl_reg[CTRL_FL1_BIT]),
    .full_ok        (use1[1]),
    .empty_ok       (use1[0]),
    .out_sync       (filt_reg[6 + DW +: DW]),
    .busy           (busy[1]),
    .err            (cerr[1]),
    .rdata          (rd1),
    .w_n            (w1_n),
    .r_n            (r1_n),
    .fifo_reset_n   (fifo_reset1_n),
    .retransmit_n   (retransmit1_n),
    .in_bus         (in_bus1)
  );
endmodule
`default_nettype wire

// ---- logic/afx_pkg.sv ----
// Package of offsets, fields and timing counts for the dual FIFO controller.
`default_nettype none
package afx_pkg;
  // ==========================================================================
  // Register offsets on APB (byte addresses).
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD0   = 8'h04;
  localparam logic [7:0] OFF_CMD1   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RDATA0 = 8'h10;
  localparam logic [7:0] OFF_RDATA1 = 8'h14;
  // ==========================================================================
  // Field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FL0_BIT  = 2;
  localparam int CTRL_FL1_BIT  = 3;
  localparam int CMD_DATA_LSB  = 0;
  localparam int CMD_OP_LSB    = 20;
  localparam int ST_CH1_LSB    = 8;
  localparam int ST_COMP_LSB   = 16;
  localparam logic [3:0] CTRL_RESET = 4'hC;
  // ==========================================================================
  // Data width and channel mode.
  localparam int DW = 9;
  localparam logic [1:0] MODE_INDEP = 2'h0;
  localparam logic [1:0] MODE_WIDTH = 2'h1;
  localparam logic [1:0] MODE_DEPTH = 2'h2;
  // Command codes.
  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_READ  = 3'h3;
  localparam logic [2:0] OP_RETX  = 3'h4;
  // ==========================================================================
  // Timing: figures in ns, counts at 125 MHz, least times rounded up.
  localparam int CLK_PS       = 8000;
  localparam int SYNC_STAGES  = 3;
  localparam int T_STROBE_NS  = 15;
  localparam int T_ACCESS_NS  = 15;
  localparam int T_FLAG_NS    = 25;
  localparam int T_RESET_NS   = 15;
  localparam int T_RST_REC_NS = 15;
  localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ACC_CYC    = (T_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FLAG_CYC   = (T_FLAG_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RESET_CYC  = (T_RESET_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RREC_CYC   = (T_RST_REC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [4:0] WR_LOW_CNT = 5'(STROBE_CYC - 1);
  localparam logic [4:0] RD_LOW_CNT = 5'(ACC_CYC + SYNC_STAGES);
  localparam logic [4:0] RS_LOW_CNT = 5'(RESET_CYC - 1);
  localparam logic [4:0] REC_CNT    = 5'(FLAG_CYC + SYNC_STAGES);
  localparam logic [4:0] RS_REC_CNT = 5'(RREC_CYC + FLAG_CYC + SYNC_STAGES);
  typedef enum logic [1:0] {AFX_IDLE, AFX_LOW, AFX_HIGH} afx_state_e;
endpackage
`default_nettype wire

// ---- verif/afx_ctrl_sva.sv ----
// Checker of the controller's FIFO pin sequencing.
`default_nettype none
module afx_ctrl_sva
  import afx_pkg::*;
(
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // Channel pins
  input wire logic          w0_n,
  input wire logic          r0_n,
  input wire logic          w1_n,
  input wire logic          fifo_reset0_n,
  input wire logic [DW-1:0] in_bus0,
  input wire logic          full_flag0_n,
  input wire logic          empty_flag0_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Pulse shapes, gaps and flag gating.
  sequence two_low(s);
    !s ##1 s;
  endsequence
  sequence pins_idle;
    (w0_n && r0_n)[*7];
  endsequence
  wr_width_a: assert property ($fell(w0_n) |=> two_low(w0_n))
    else $error("write strobe width wrong");
  ch1_width_a: assert property ($fell(w1_n) |=> two_low(w1_n))
    else $error("channel 1 write strobe width wrong");
  rst_width_a: assert property (
    $fell(fifo_reset0_n) |=> two_low(fifo_reset0_n))
    else $error("reset pulse width wrong");
  rd_width_a: assert property (
    $fell(r0_n) |=> (!r0_n)[*5] ##1 r0_n)
    else $error("read strobe width wrong");
  rst_quiet_a: assert property (
    !fifo_reset0_n |-> w0_n && r0_n)
    else $error("strobe active during reset");
  data_hold_a: assert property (
    $fell(w0_n) |=> $stable(in_bus0)[*2])
    else $error("write data moved under strobe");
  wr_recover_a: assert property ($rose(w0_n) |-> pins_idle)
    else $error("strobe too soon after write");
  full_block_a: assert property (
    $fell(w0_n) |-> full_flag0_n && $past(full_flag0_n, 6))
    else $error("write strobe while full");
  empty_block_a: assert property (
    $fell(r0_n) |-> empty_flag0_n && $past(empty_flag0_n, 6))
    else $error("read strobe while empty");
endmodule
bind afx_ctrl afx_ctrl_sva chk_u (.*);
`default_nettype wire

// ---- verif/afx_fifo_model.sv ----
// Pin-level model of one asynchronous FIFO channel.
`default_nettype none
module afx_fifo_model
  import afx_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // Controls
  input  wire logic          w_n,
  input  wire logic          r_n,
  input  wire logic          fifo_reset_n,
  input  wire logic          retransmit_n,
  // Data and flags
  input  wire logic [DW-1:0] in_bus,
  output logic [DW-1:0]      out_bus,
  output logic               full_flag_n,
  output logic               empty_flag_n,
  output logic               half_full_flag_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Storage and pointers.
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] word_q = 9'h000;
  logic          half_q = 1'b1;
  logic          wr_ok  = 1'b0;
  logic          rd_ok  = 1'b0;
  int            wp     = 0;
  int            rp     = 0;
  int            cnt    = 0;
  always @(negedge fifo_reset_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    half_q = 1'b1;
  end
  always @(negedge w_n) begin
    wr_ok = fifo_reset_n && cnt < DEPTH;
    if (wr_ok && cnt >= DEPTH / 2) half_q = 1'b0;
  end
  always @(posedge w_n) if (wr_ok) begin
    mem[wp] = in_bus;
    wp = (wp + 1) % DEPTH;
    cnt++;
    wr_ok = 1'b0;
  end
  always @(negedge r_n) begin
    rd_ok = fifo_reset_n && cnt > 0;
    if (rd_ok) word_q = mem[rp];
    if (rd_ok) rp = (rp + 1) % DEPTH;
  end
  always @(posedge r_n) if (rd_ok) begin
    cnt--;
    if (cnt <= DEPTH / 2) half_q = 1'b1;
    rd_ok = 1'b0;
  end
  always @(negedge retransmit_n) if (w_n && r_n) begin
    rp = 0;
    cnt = wp;
  end
  // A released bus shows the inverse of the last word, never a held copy.
  assign out_bus          = r_n ? ~word_q : word_q;
  assign full_flag_n      = cnt != DEPTH;
  assign empty_flag_n     = cnt != 0;
  assign half_full_flag_n = half_q;
endmodule
`default_nettype wire

// ---- verif/test_afx_ctrl.sv ----
// Self-checking bench for the dual FIFO host controller.
`default_nettype none
module test_afx_ctrl
  import afx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 8;
  logic          pclk    = 1'b0;
  logic          presetn = 1'b0;
  logic          psel    = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite  = 1'b0;
  logic [7:0]    paddr   = 8'h00;
  logic [31:0]   pwdata  = 32'h0000_0000;
  logic [31:0]   prdata, rd_val;
  logic          pready, pslverr, rd_err;
  logic          w0_n, r0_n, fifo_reset0_n, retransmit0_n;
  logic          w1_n, r1_n, fifo_reset1_n, retransmit1_n;
  logic          full_flag0_n, empty_flag0_n, half_full_flag0_n;
  logic          full_flag1_n, empty_flag1_n, half_full_flag1_n;
  logic [DW-1:0] in_bus0, in_bus1, out_bus0, out_bus1;
  int            num_errors  = 0;
  int            checks_done = 0;
  // ==========================================================================
  // Design and the two FIFO channels.
  always #4 pclk = ~pclk;
  afx_ctrl dut_u (.*);
  afx_fifo_model #(.DEPTH(DEPTH)) fifo0_u (.w_n(w0_n), .r_n(r0_n),
    .fifo_reset_n(fifo_reset0_n), .retransmit_n(retransmit0_n),
    .in_bus(in_bus0), .out_bus(out_bus0), .full_flag_n(full_flag0_n),
    .empty_flag_n(empty_flag0_n), .half_full_flag_n(half_full_flag0_n));
  afx_fifo_model #(.DEPTH(DEPTH)) fifo1_u (.w_n(w1_n), .r_n(r1_n),
    .fifo_reset_n(fifo_reset1_n), .retransmit_n(retransmit1_n),
    .in_bus(in_bus1), .out_bus(out_bus1), .full_flag_n(full_flag1_n),
    .empty_flag_n(empty_flag1_n), .half_full_flag_n(half_full_flag1_n));
  // ==========================================================================
  // Bus and compare tasks.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_val = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stat(input int ch, input logic [4:0] exp);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({27'h0, rd_val[ch*8 +: 5]}, {27'h0, exp});
  endtask
  // Busy shows one cycle after the go pulse, so polling waits an edge.
  task automatic cmdw(input int ch, input logic [2:0] op,
                      input logic [2*DW-1:0] d);
    apb(1'b1, ch ? OFF_CMD1 : OFF_CMD0,
        (32'(op) << CMD_OP_LSB) | {14'h0, d});
    @(posedge pclk);
    do apb(1'b0, OFF_STATUS, 32'h0000_0000);
    while (rd_val[ch*8+3] !== 1'b0);
  endtask
  task automatic cmd(input int ch, input logic [2:0] op,
                     input logic [DW-1:0] d);
    cmdw(ch, op, {9'h000, d});
  endtask
  task automatic rdchk(input int ch, input logic [DW-1:0] exp);
    cmd(ch, OP_READ, 9'h000);
    apb(1'b0, ch ? OFF_RDATA1 : OFF_RDATA0, 32'h0000_0000);
    chk(rd_val, {23'h0, exp});
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_regs();
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(rd_val & 32'h0000_000F, {28'h0, CTRL_RESET});
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({31'h0, rd_err}, 32'h0000_0001);
    cmd(0, OP_RESET, 9'h000);
    cmd(1, OP_RESET, 9'h000);
    stat(0, 5'h06);
    stat(1, 5'h06);
  endtask
  task automatic t_fill();
    for (int i = 0; i < DEPTH; i++) begin
      cmd(0, OP_WRITE, 9'(9'h100 + i));
      stat(0, {2'b00, i < DEPTH / 2, i != DEPTH - 1, 1'b1});
    end
    cmd(0, OP_WRITE, 9'h0AA);
    stat(0, 5'h11);
    for (int i = 0; i < DEPTH; i++) begin
      rdchk(0, 9'(9'h100 + i));
      stat(0, {2'b00, i >= DEPTH / 2 - 1, 1'b1, i != DEPTH - 1});
    end
    cmd(0, OP_READ, 9'h000);
    stat(0, 5'h16);
  endtask
  task automatic t_retx();
    for (int i = 0; i < 3; i++) cmd(1, OP_WRITE, 9'(9'h050 + i));
    rdchk(1, 9'h050);
    cmd(1, OP_RETX, 9'h000);
    for (int i = 0; i < 3; i++) rdchk(1, 9'(9'h050 + i));
    stat(1, 5'h06);
    stat(0, 5'h16);
  endtask
  // Channel 1 holds a word and channel 0 is empty, so only an OR of the
  // active-low flags reports the chain as not empty.
  task automatic t_depth();
    cmd(0, OP_RESET, 9'h000);
    cmd(1, OP_RESET, 9'h000);
    cmd(1, OP_WRITE, 9'h0C3);
    apb(1'b1, OFF_CTRL, 32'h0000_000A);
    chk({30'h0, retransmit1_n, retransmit0_n}, 32'h0000_0002);
    cmd(0, OP_RETX, 9'h000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({28'h0, rd_val[18:16], rd_val[4]}, 32'h0000_000F);
  endtask
  task automatic t_width();
    apb(1'b1, OFF_CTRL, 32'h0000_000D);
    cmd(0, OP_RESET, 9'h000);
    cmdw(0, OP_WRITE, 18'h2A5B3);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk({29'h0, rd_val[18:16]}, 32'h0000_0007);
    cmd(0, OP_READ, 9'h000);
    apb(1'b0, OFF_RDATA0, 32'h0000_0000);
    chk(rd_val, 32'h0002_A5B3);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fill();
    t_retx();
    t_depth();
    t_width();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
